/* ccp_clock_ctrl.sv */
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ccp_defs.svh"
module ccp_clock_ctrl
  import ccp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_irc_osc,
  input wire logic i_main_osc,
  input wire logic i_rtc_osc,
  input wire logic i_pll_lock,
  input wire logic i_sleep_enter,
  input wire logic i_pwrdn_enter,
  input wire logic i_wake,
  output logic [1:0] o_pll_input_clock_sel,
  output logic o_pll_enable,
  output logic o_pll_connect,
  output logic o_pll_bypass,
  output logic [7:0] o_pll_n,
  output logic [14:0] o_pll_m,
  output logic [7:0] o_cpu_clock_div,
  output logic [3:0] o_usb_clock_div,
  output logic o_main_osc_enable,
  output logic [1:0] o_watchdog_timer_src,
  output logic o_rtc_from_osc,
  output logic [`CCP_NUM_PERIPH-1:0] o_pclk_en,
  output logic o_cpu_run
);
  // ==========================================================
  // pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  localparam int NSYNC = 4;
  wire [NSYNC-1:0] pin_in = {i_pll_lock, i_rtc_osc, i_main_osc, i_irc_osc};
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync3;
  logic [NSYNC-1:0] filt;
  logic [NSYNC-1:0] filt_d;

  genvar gs;
  generate
    for (gs = 0; gs < NSYNC; gs = gs + 1) begin : g_sync
      always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
          sync1[gs] <= 1'b0;
          sync2[gs] <= 1'b0;
          sync3[gs] <= 1'b0;
          filt[gs] <= 1'b0;
          filt_d[gs] <= 1'b0;
        end else begin
          sync1[gs] <= pin_in[gs];
          sync2[gs] <= sync1[gs];
          sync3[gs] <= sync2[gs];
          if (sync2[gs] == sync3[gs]) begin
            filt[gs] <= sync3[gs];
          end
          filt_d[gs] <= filt[gs];
        end
      end
    end
  endgenerate

  // oscillators faster than a quarter of the system clock lose one-cycle pulses in the filter; ticks then undercount
  wire [NSYNC-1:0] rise = filt & ~filt_d;
  wire irc_tick = rise[0];
  wire main_tick = rise[1];
  wire rtc_tick = rise[2];
  wire pll_locked = filt[3];

  // ==========================================================
  // control registers
  ccp_src_t src_sel;
  ccp_pwr_t pwr_state;
  ccp_src_t sleep_src;
  logic [7:0] pll_n;
  logic [14:0] pll_m;
  logic pll_en;
  logic pll_conn;
  logic main_en;
  logic [7:0] cpu_div;
  logic [3:0] usb_div;
  logic [2*`CCP_NUM_PERIPH-1:0] pclk_sel;
  ccp_wdt_t wdt_src;
  logic rtc_osc_sel;
  logic [31:0] rdata;
  logic main_ready;
  logic resume_done;

  wire wr_clksrc = i_wr && (i_addr == `CCP_ADDR_CLKSRC);
  wire wr_pllcfg = i_wr && (i_addr == `CCP_ADDR_PLLCFG);
  wire wr_pllcon = i_wr && (i_addr == `CCP_ADDR_PLLCON);
  wire wr_oscctl = i_wr && (i_addr == `CCP_ADDR_OSCCTL);
  wire wr_clkdiv = i_wr && (i_addr == `CCP_ADDR_CLKDIV);
  wire wr_pclksel = i_wr && (i_addr == `CCP_ADDR_PCLKSEL);
  wire wr_wdtsel = i_wr && (i_addr == `CCP_ADDR_WDTSEL);

  wire in_run = (pwr_state == ccp_st_run);
  wire sleep_go = in_run && i_sleep_enter;
  wire pwrdn_go = in_run && i_pwrdn_enter && !i_sleep_enter;
  wire pwrdn_wake = (pwr_state == ccp_st_pwrdn) && i_wake;
  wire sleep_wake = (pwr_state == ccp_st_sleep) && i_wake;

  // unsupported select code 2'b11 falls back to the RC oscillator
  wire [1:0] wsrc = i_wdata[`CCP_CLKSRC_SEL];
  wire ccp_src_t next_src = (wsrc == ccp_src_main) ? ccp_src_main :
                            (wsrc == ccp_src_rtc) ? ccp_src_rtc : ccp_src_irc;
  wire [1:0] wwdt = i_wdata[`CCP_WDTSEL_SRC];
  wire ccp_wdt_t next_wdt = (wwdt == ccp_wdt_rtc) ? ccp_wdt_rtc :
                            (wwdt == ccp_wdt_pclk) ? ccp_wdt_pclk : ccp_wdt_irc;

  // main oscillator is held off the clock path until the wake-up timer expires
  wire main_blocked = (src_sel == ccp_src_main) && !main_ready;
  wire ccp_src_t eff_src = main_blocked ? ccp_src_irc : src_sel;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      src_sel <= ccp_src_irc;
    end else if (pwrdn_wake) begin
      src_sel <= ccp_src_irc;
    end else if (wr_clksrc) begin
      src_sel <= next_src;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pll_n <= `CCP_RST_PLLN;
      pll_m <= `CCP_RST_PLLM;
    end else if (wr_pllcfg) begin
      pll_n <= i_wdata[`CCP_PLLCFG_N];
      pll_m <= i_wdata[`CCP_PLLCFG_M];
    end
  end

  // hardware events win over a write in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pll_en <= 1'b0;
      pll_conn <= 1'b0;
    end else if (sleep_go || pwrdn_go) begin
      pll_en <= 1'b0;
      pll_conn <= 1'b0;
    end else if (wr_pllcon) begin
      pll_en <= i_wdata[`CCP_PLLCON_EN];
      pll_conn <= i_wdata[`CCP_PLLCON_CONN];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      main_en <= 1'b0;
    end else if (pwrdn_go) begin
      main_en <= 1'b0;
    end else if (wr_oscctl) begin
      main_en <= i_wdata[`CCP_OSCCTL_EN];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      cpu_div <= `CCP_RST_CPUDIV;
      usb_div <= `CCP_RST_USBDIV;
    end else if (sleep_go) begin
      cpu_div <= `CCP_RST_CPUDIV;
      usb_div <= `CCP_RST_USBDIV;
    end else if (wr_clkdiv) begin
      cpu_div <= i_wdata[`CCP_CLKDIV_CPU];
      usb_div <= i_wdata[`CCP_CLKDIV_USB];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pclk_sel <= `CCP_RST_PCLKSEL;
    end else if (wr_pclksel) begin
      pclk_sel <= i_wdata[`CCP_PCLKSEL_ALL];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      wdt_src <= ccp_wdt_irc;
      rtc_osc_sel <= 1'b0;
    end else if (wr_wdtsel) begin
      wdt_src <= next_wdt;
      rtc_osc_sel <= i_wdata[`CCP_WDTSEL_RTCOSC];
    end
  end

  // ==========================================================
  // power state sequencing
  ccp_pwr_t next_state;
  always_comb begin
    next_state = pwr_state;
    unique case (pwr_state)
      ccp_st_run: begin
        if (i_sleep_enter) begin
          next_state = ccp_st_sleep;
        end else if (i_pwrdn_enter) begin
          next_state = ccp_st_pwrdn;
        end
      end
      ccp_st_sleep: begin
        if (i_wake) begin
          next_state = ccp_st_resume;
        end
      end
      ccp_st_pwrdn: begin
        if (i_wake) begin
          next_state = ccp_st_run;
        end
      end
      ccp_st_resume: begin
        if (resume_done) begin
          next_state = ccp_st_run;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pwr_state <= ccp_st_run;
      sleep_src <= ccp_src_irc;
    end else begin
      pwr_state <= next_state;
      if (sleep_go) begin
        // the oscillator really clocking the core, so a blocked main source cannot hang resume
        sleep_src <= eff_src;
      end
    end
  end

  // ==========================================================
  // wake-up timers and peripheral clock divider
  ccp_wake_timer u_main_wake (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_clear(pwrdn_go),
    .i_enable(main_en),
    .i_tick(main_tick),
    .i_target(`CCP_OSC_STABLE_CYC),
    .o_done(main_ready)
  );

  wire [12:0] resume_target = (sleep_src == ccp_src_main) ? `CCP_SLEEP_MAIN_CYC :
                              `CCP_SLEEP_IRC_CYC;
  wire resume_tick = (sleep_src == ccp_src_main) ? main_tick :
                     (sleep_src == ccp_src_rtc) ? rtc_tick : irc_tick;

  ccp_wake_timer u_resume_wake (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_clear(sleep_wake),
    .i_enable(pwr_state == ccp_st_resume),
    .i_tick(resume_tick),
    .i_target(resume_target),
    .o_done(resume_done)
  );

  ccp_pclk_div u_pclk (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_sel(pclk_sel),
    .o_pclk_en(o_pclk_en)
  );

  // ==========================================================
  // register read port
  wire [31:0] rd_mux =
    (i_addr == `CCP_ADDR_CLKSRC) ? {30'h0000_0000, src_sel} :
    (i_addr == `CCP_ADDR_PLLCFG) ? {9'h000, pll_m, pll_n} :
    (i_addr == `CCP_ADDR_PLLCON) ? {30'h0000_0000, pll_conn, pll_en} :
    (i_addr == `CCP_ADDR_PLLSTAT) ? {29'h0000_0000, pll_locked, pll_conn, pll_en} :
    (i_addr == `CCP_ADDR_OSCCTL) ? {30'h0000_0000, main_ready, main_en} :
    (i_addr == `CCP_ADDR_CLKDIV) ? {20'h0_0000, usb_div, cpu_div} :
    (i_addr == `CCP_ADDR_PCLKSEL) ? {24'h00_0000, pclk_sel} :
    (i_addr == `CCP_ADDR_WDTSEL) ? {29'h0000_0000, rtc_osc_sel, wdt_src} :
    `CCP_RST_DATA;

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      rdata <= `CCP_RST_DATA;
    end else begin
      rdata <= i_rd ? rd_mux : `CCP_RST_DATA;
    end
  end

  // ==========================================================
  // outputs
  wire pll_active = pll_en && pll_conn;

  assign o_rdata = rdata;
  assign o_pll_input_clock_sel = eff_src;
  assign o_pll_enable = pll_en;
  assign o_pll_connect = pll_active;
  assign o_pll_bypass = !pll_active;
  assign o_pll_n = pll_n;
  assign o_pll_m = pll_m;
  assign o_cpu_clock_div = cpu_div;
  assign o_usb_clock_div = usb_div;
  assign o_main_osc_enable = main_en;
  assign o_watchdog_timer_src = wdt_src;
  assign o_rtc_from_osc = rtc_osc_sel;
  assign o_cpu_run = in_run;
endmodule
`default_nettype wire

/* ccp_defs.svh */
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH
// Function
// - software picks internal RC, main or RTC oscillator as PLL input clock.
// - after any reset the internal RC oscillator is the source until software changes it.
// - 4 MHz internal RC oscillator can clock the watchdog timer and the PLL.
// - RTC oscillator can clock the RTC, the watchdog timer and the PLL.
// - CPU clock equals PLL input clock unless PLL is both enabled and connected.
// - each peripheral has its own selectable clock rate derived from system clock.
// - PLL pre-divider N takes any integer 1 to 256.
// - PLL feedback divider M takes any integer 1 to 32768.
// - PLL output is divided separately for the CPU clock and the USB clock.
// - PLL is off and bypassed after reset and on power-down entry.
// - only a software write enables the PLL.
// - power-up and wake from power-down resume on the internal RC oscillator.
// - wake-up timer blocks main oscillator as CPU clock until proven running.
// - sleep wake resumes after 4 cycles on RC, 4096 on main oscillator.

// ==========================================================
// register offsets
`define CCP_ADDR_CLKSRC 8'h00
`define CCP_ADDR_PLLCFG 8'h04
`define CCP_ADDR_PLLCON 8'h08
`define CCP_ADDR_PLLSTAT 8'h0C
`define CCP_ADDR_OSCCTL 8'h10
`define CCP_ADDR_CLKDIV 8'h14
`define CCP_ADDR_PCLKSEL 8'h18
`define CCP_ADDR_WDTSEL 8'h1C

// ==========================================================
// field positions
`define CCP_CLKSRC_SEL 1:0
`define CCP_PLLCFG_N 7:0
`define CCP_PLLCFG_M 22:8
`define CCP_PLLCON_EN 0
`define CCP_PLLCON_CONN 1
`define CCP_PLLSTAT_LOCK 2
`define CCP_OSCCTL_EN 0
`define CCP_OSCCTL_RDY 1
`define CCP_CLKDIV_CPU 7:0
`define CCP_CLKDIV_USB 11:8
`define CCP_PCLKSEL_ALL 7:0
`define CCP_WDTSEL_SRC 1:0
`define CCP_WDTSEL_RTCOSC 2

// ==========================================================
// reset values and counts
`define CCP_RST_PLLN 8'h00
`define CCP_RST_PLLM 15'h0000
`define CCP_RST_CPUDIV 8'h00
`define CCP_RST_USBDIV 4'h0
`define CCP_RST_PCLKSEL 8'h00
`define CCP_RST_DATA 32'h0000_0000
`define CCP_CNT_ZERO 13'h0000
`define CCP_SLEEP_IRC_CYC 13'h0004
`define CCP_SLEEP_MAIN_CYC 13'h1000
`define CCP_OSC_STABLE_CYC 13'h1000
`define CCP_IRC_FREQ_HZ 4000000
`define CCP_NUM_PERIPH 4
`define CCP_PDIV_W 3
`endif

/* ccp_pkg.sv */
package ccp_pkg;
  typedef enum logic [1:0] {
    ccp_src_irc = 2'b00,
    ccp_src_main = 2'b01,
    ccp_src_rtc = 2'b10
  } ccp_src_t;

  typedef enum logic [1:0] {
    ccp_wdt_irc = 2'b00,
    ccp_wdt_rtc = 2'b01,
    ccp_wdt_pclk = 2'b10
  } ccp_wdt_t;

  typedef enum logic [1:0] {
    ccp_st_run = 2'b00,
    ccp_st_sleep = 2'b01,
    ccp_st_pwrdn = 2'b10,
    ccp_st_resume = 2'b11
  } ccp_pwr_t;
endpackage

/* ccp_wake_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ccp_defs.svh"
module ccp_wake_timer (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_clear,
  input wire logic i_enable,
  input wire logic i_tick,
  input wire logic [12:0] i_target,
  output logic o_done
);
  logic [12:0] cnt;
  logic done;
  wire reached = (cnt == i_target);
  wire [12:0] next_cnt = reached ? cnt : cnt + 13'h0001;

  // ==========================================================
  // counts ticks of the watched oscillator while enabled
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst || i_clear || !i_enable) begin
      cnt <= `CCP_CNT_ZERO;
      done <= 1'b0;
    end else begin
      if (i_tick) begin
        cnt <= next_cnt;
      end
      done <= reached;
    end
  end

  assign o_done = done;
endmodule
`default_nettype wire

/* ccp_pclk_div.sv */
`timescale 1ns/100ps
`default_nettype none
`include "ccp_defs.svh"
module ccp_pclk_div (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [2*`CCP_NUM_PERIPH-1:0] i_sel,
  output logic [`CCP_NUM_PERIPH-1:0] o_pclk_en
);
  // select code k divides the system clock by 2**k
  function automatic logic [`CCP_PDIV_W-1:0] div_limit(input logic [1:0] sel);
    logic [`CCP_PDIV_W-1:0] lim;
    lim = 3'h0;
    unique case (sel)
      2'b00: lim = 3'h0;
      2'b01: lim = 3'h1;
      2'b10: lim = 3'h3;
      2'b11: lim = 3'h7;
    endcase
    return lim;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `CCP_NUM_PERIPH; gi = gi + 1) begin : g_per
      logic [`CCP_PDIV_W-1:0] cnt;
      logic en;
      wire [`CCP_PDIV_W-1:0] lim = div_limit(i_sel[2*gi+1:2*gi]);
      wire wrap = (cnt >= lim);
      always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
          cnt <= 3'h0;
          en <= 1'b0;
        end else begin
          cnt <= wrap ? 3'h0 : cnt + 3'h1;
          en <= wrap;
        end
      end
      assign o_pclk_en[gi] = en;
    end
  endgenerate
endmodule
`default_nettype wire

/* ccp_clock_ctrl_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ccp_clock_ctrl_chk (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_sleep_enter,
  input wire logic i_pwrdn_enter,
  input wire logic i_wake,
  input wire logic [1:0] o_pll_input_clock_sel,
  input wire logic o_pll_enable,
  input wire logic o_pll_connect,
  input wire logic o_pll_bypass,
  input wire logic [7:0] o_pll_n,
  input wire logic [14:0] o_pll_m,
  input wire logic [7:0] o_cpu_clock_div,
  input wire logic [3:0] o_usb_clock_div,
  input wire logic o_main_osc_enable,
  input wire logic o_cpu_run
);
  logic pd;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // ==========
  // power-down tracking
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) pd <= 1'b0;
    else if (o_cpu_run && i_pwrdn_enter && !i_sleep_enter) pd <= 1'b1;
    else if (i_wake) pd <= 1'b0;
  end
  // ==========
  // properties
  a_bypass_inverse: assert property (o_pll_bypass == !o_pll_connect)
    else $error("bypass is not the inverse of connect");
  a_connect_needs_en: assert property (o_pll_connect |-> o_pll_enable
    && ($past(o_pll_connect) || ($past(i_wr) && $past(i_addr) == 8'h08)))
    else $error("pll connected while disabled");
  a_enable_by_sw: assert property ($rose(o_pll_enable) |->
    $past(i_wr) && $past(i_addr) == 8'h08) else $error("pll enabled without a write");
  a_reset_irc: assert property (disable iff (1'b0) !i_nrst |=>
    o_pll_input_clock_sel == 2'b00 && !o_pll_enable && o_pll_bypass && o_cpu_run)
    else $error("reset state wrong");
  a_pwrdn_pll_off: assert property (o_cpu_run && i_pwrdn_enter && !i_sleep_enter |=>
    !o_cpu_run && !o_pll_enable && !o_main_osc_enable) else $error("power-down entry wrong");
  a_sleep_clears: assert property (o_cpu_run && i_sleep_enter |=>
    !o_cpu_run && !o_pll_enable && o_cpu_clock_div == 8'h00 && o_usb_clock_div == 4'h0)
    else $error("sleep entry wrong");
  a_pwrdn_wake_irc: assert property (pd && i_wake |=>
    o_cpu_run && o_pll_input_clock_sel == 2'b00) else $error("power-down wake not on rc");
  a_main_wait: assert property ($rose(o_pll_input_clock_sel == 2'b01) |->
    o_main_osc_enable && $past(o_main_osc_enable, 8)) else $error("main used before stable");
  a_cfg_follow: assert property (i_wr && i_addr == 8'h04 |=>
    o_pll_n == $past(i_wdata[7:0]) && o_pll_m == $past(i_wdata[22:8]))
    else $error("pll dividers not updated");
  a_src_rtc: assert property (i_wr && i_addr == 8'h00 && i_wdata[1:0] == 2'b10
    && o_cpu_run && !i_sleep_enter && !i_pwrdn_enter |=> o_pll_input_clock_sel == 2'b10)
    else $error("rtc source not selected");
  a_status_read: assert property (i_rd && i_addr == 8'h0C |=>
    o_rdata[1:0] == $past({o_pll_connect, o_pll_enable})) else $error("pll status read wrong");
endmodule
bind ccp_clock_ctrl ccp_clock_ctrl_chk ccp_clock_ctrl_chk_inst (.i_clk_sys, .i_nrst, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_sleep_enter, .i_pwrdn_enter, .i_wake,
  .o_pll_input_clock_sel, .o_pll_enable, .o_pll_connect, .o_pll_bypass, .o_pll_n, .o_pll_m,
  .o_cpu_clock_div, .o_usb_clock_div, .o_main_osc_enable, .o_cpu_run);
`default_nettype wire

/* ccp_osc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ccp_osc_model (
  input wire logic i_clk_sys,
  input wire logic i_main_en,
  input wire logic i_pll_en,
  output logic o_irc,
  output logic o_main,
  output logic o_rtc,
  output logic o_lock
);
  logic [3:0] ph = 4'h0;
  logic [4:0] lk = 5'h00;
  always @(posedge i_clk_sys) begin
    ph <= ph + 4'h1;
    lk <= !i_pll_en ? 5'h00 : (lk == 5'h1F) ? lk : lk + 5'h01;
  end
  assign o_irc = ph[1];
  // crystal stands low while disabled
  assign o_main = i_main_en & ph[1];
  assign o_rtc = ph[3];
  assign o_lock = (lk == 5'h1F);
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin err_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [2:0] ev = 3'h0;
  wire i_sleep_enter = ev[0];
  wire i_pwrdn_enter = ev[1];
  wire i_wake = ev[2];
  wire i_irc_osc, i_main_osc, i_rtc_osc, i_pll_lock;
  wire [31:0] o_rdata;
  wire [1:0] o_pll_input_clock_sel, o_watchdog_timer_src;
  wire o_pll_enable, o_pll_connect, o_pll_bypass, o_main_osc_enable, o_rtc_from_osc, o_cpu_run;
  wire [7:0] o_pll_n, o_cpu_clock_div;
  wire [14:0] o_pll_m;
  wire [3:0] o_usb_clock_div, o_pclk_en;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, k, j, dt;
  int cnt [4];
  logic [31:0] d;
  always #12.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) cyc <= cyc + 1;
  ccp_clock_ctrl ccp_clock_ctrl_inst (.i_clk_sys, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_irc_osc, .i_main_osc, .i_rtc_osc, .i_pll_lock, .i_sleep_enter,
    .i_pwrdn_enter, .i_wake, .o_pll_input_clock_sel, .o_pll_enable, .o_pll_connect,
    .o_pll_bypass, .o_pll_n, .o_pll_m, .o_cpu_clock_div, .o_usb_clock_div, .o_main_osc_enable,
    .o_watchdog_timer_src, .o_rtc_from_osc, .o_pclk_en, .o_cpu_run);
  ccp_osc_model ccp_osc_model_inst (.i_clk_sys, .i_main_en(o_main_osc_enable),
    .i_pll_en(o_pll_enable), .o_irc(i_irc_osc), .o_main(i_main_osc), .o_rtc(i_rtc_osc),
    .o_lock(i_pll_lock));
  // ==========
  // bus and event tasks
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask
  task pulse(input logic [2:0] e);
    @(posedge i_clk_sys);
    ev <= e;
    @(posedge i_clk_sys);
    ev <= 3'h0;
    #1;
    t0 = cyc;
  endtask
  task pll_up;
    wr(8'h08, 32'h0000_0001);
    d = 32'h0;
    for (k = 0; k < 60 && d[2] !== 1'b1; k++) rd(8'h0C, d);
    wr(8'h08, 32'h0000_0003);
  endtask
  task wait_run;
    for (k = 0; k < 20000 && o_cpu_run !== 1'b1; k++) begin
      @(posedge i_clk_sys);
      #1;
    end
    dt = cyc - t0;
  endtask
  task rst_chk;
    @(posedge i_clk_sys);
    i_nrst <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    #1;
    d = {o_pll_input_clock_sel, o_pll_enable, o_pll_connect, o_pll_bypass, o_cpu_run,
      o_main_osc_enable};
    `CHK("reset ctrl", 7'b0000110, d[6:0])
    `CHK("reset div", 35'h0, {o_pll_n, o_pll_m, o_cpu_clock_div, o_usb_clock_div})
    rd(8'h00, d);
    `CHK("reset src", 32'h0, d)
  endtask
  task done(input string s);
    $display("test %s finished, mismatches so far %0d", s, err_count);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    err_count++;
    final_report();
  end
  // ==========
  // test sequence
  initial begin
    rst_chk();
    rd(8'h20, d);
    `CHK("unmapped", 32'h0, d)
    wr(8'h04, 32'h007F_FFFF);
    `CHK("pll nm max", 23'h7FFFFF, {o_pll_m, o_pll_n})
    wr(8'h04, 32'h0000_0000);
    `CHK("pll nm min", 23'h0, {o_pll_m, o_pll_n})
    wr(8'h14, 32'h0000_05A3);
    `CHK("dividers", 12'h5A3, {o_usb_clock_div, o_cpu_clock_div})
    wr(8'h1C, 32'h0000_0005);
    `CHK("wdt rtc", 3'b101, {o_rtc_from_osc, o_watchdog_timer_src})
    wr(8'h1C, 32'h0000_0003);
    `CHK("wdt irc", 3'b000, {o_rtc_from_osc, o_watchdog_timer_src})
    wr(8'h1C, 32'h0000_0002);
    `CHK("wdt pclk", 3'b010, {o_rtc_from_osc, o_watchdog_timer_src})
    for (j = 0; j < 4; j++) begin
      wr(8'h00, j);
      `CHK("src sel", (j == 2) ? 2'b10 : 2'b00, o_pll_input_clock_sel)
    end
    wr(8'h18, 32'h0000_0039);
    cnt = '{0, 0, 0, 0};
    for (k = 0; k < 16; k++) begin
      @(posedge i_clk_sys);
      #1;
      for (j = 0; j < 4; j++) cnt[j] += o_pclk_en[j];
    end
    for (j = 0; j < 4; j++) `CHK("pclk pulses", 16 >> ((8'h39 >> (2 * j)) & 3), cnt[j])
    done("registers");
    wr(8'h04, 32'h0000_6300);
    `CHK("pll cfg", 23'h006300, {o_pll_m, o_pll_n})
    wr(8'h08, 32'h0000_0001);
    `CHK("pll on", 3'b101, {o_pll_enable, o_pll_connect, o_pll_bypass})
    d = 32'h0;
    for (k = 0; k < 60 && d[2] !== 1'b1; k++) rd(8'h0C, d);
    `CHK("pll lock", 3'b101, d[2:0])
    wr(8'h08, 32'h0000_0003);
    `CHK("pll conn", 2'b10, {o_pll_connect, o_pll_bypass})
    wr(8'h08, 32'h0000_0002);
    `CHK("conn only", 3'b001, {o_pll_enable, o_pll_connect, o_pll_bypass})
    done("pll");
    wr(8'h10, 32'h0000_0001);
    t0 = cyc;
    rd(8'h10, d);
    `CHK("osc early", 2'b01, d[1:0])
    for (k = 0; k < 10000 && d[1] !== 1'b1; k++) rd(8'h10, d);
    `CHK("osc ready time", 1'b1, (cyc - t0 > 16370 && cyc - t0 < 16450))
    wr(8'h00, 32'h0000_0001);
    `CHK("src main", 2'b01, o_pll_input_clock_sel)
    pll_up();
    done("main osc");
    pulse(3'b001);
    d = {o_cpu_run, o_pll_enable, o_pll_connect, o_usb_clock_div, o_cpu_clock_div};
    `CHK("sleep", 15'h0, d[14:0])
    pulse(3'b100);
    wait_run();
    `CHK("main resume", 1'b1, (dt > 16370 && dt < 16450))
    wr(8'h00, 32'h0000_0000);
    pulse(3'b001);
    pulse(3'b100);
    wait_run();
    `CHK("rc resume", 1'b1, (dt > 12 && dt < 40))
    done("sleep");
    wr(8'h00, 32'h0000_0001);
    pll_up();
    pulse(3'b010);
    `CHK("pwrdn", 3'b000, {o_cpu_run, o_pll_enable, o_main_osc_enable})
    pulse(3'b100);
    `CHK("pwrdn wake", 3'b100, {o_cpu_run, o_pll_input_clock_sel})
    rd(8'h00, d);
    `CHK("wake src", 32'h0, d)
    rd(8'h10, d);
    `CHK("wake osc", 32'h0, d)
    done("power-down");
    wr(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_0002);
    rst_chk();
    done("second reset");
    final_report();
  end
endmodule
`default_nettype wire
